//--- design/mir_flags.sv
/*
 Sticky event flags, set by hardware, cleared by write-one.
 Assumes set and clear vectors are single-cycle pulses in hclk.
*/
`timescale 1ns/1ps
module mir_flags #(
   parameter int W = 7
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] flags
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // Set wins so an event in the clearing cycle survives
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               flags[i] <= 1'b0;
            end else if (set[i]) begin
               flags[i] <= 1'b1;
            end else if (clr[i]) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule

//--- design/mir_pkg.sv
/*
 Shared constants and carrier types of the maintenance interrupt block.
 Assumes a 32-bit AHB-Lite register bus and one system clock.
*/
package mir_pkg;
   // Decoded address bits; the block sits behind its own hsel
   localparam int MIR_AW = 17;
   localparam logic [MIR_AW-1:0] MIR_OFF_STATUS = 17'h10080;
   localparam logic [MIR_AW-1:0] MIR_OFF_ENABLE = 17'h10084;
   localparam logic [MIR_AW-1:0] MIR_OFF_RXBASE = 17'h10088;
   localparam logic [MIR_AW-1:0] MIR_OFF_PWSTAT = 17'h1008C;
   localparam logic [MIR_AW-1:0] MIR_OFF_PWCTRL = 17'h10090;
   localparam logic [MIR_AW-1:0] MIR_OFF_WINEN = 17'h10094;
   localparam logic [MIR_AW-1:0] MIR_OFF_PWBUF = 17'h100C0;
   localparam int MIR_BUF_LSB = 2;
   localparam int MIR_BUF_AW = 4;
   localparam int MIR_BUF_DEPTH = 16;
   // Event vector layout, shared by status and enable
   localparam int MIR_EV_W = 7;
   localparam int MIR_EV_RD_MISS = 0;
   localparam int MIR_EV_WR_MISS = 1;
   localparam int MIR_EV_STORED = 4;
   localparam int MIR_EV_DROPPED = 5;
   localparam int MIR_EV_PW_ERR = 6;
   localparam logic [MIR_EV_W-1:0] MIR_EV_IMPL = 7'h73;
   localparam logic [MIR_EV_W-1:0] MIR_EV_RESET = 7'h00;
   // Inbound base field and own control bits
   localparam int MIR_BASE_LSB = 24;
   localparam int MIR_BASE_W = 8;
   localparam int MIR_CFG_W = 21;
   localparam int MIR_PWC_EN = 0;
   localparam int MIR_PWC_REL = 1;
   localparam int MIR_PWS_FULL = 0;
   localparam int MIR_PWS_LEN_LSB = 8;
   localparam int MIR_NWIN = 16;
   localparam int MIR_CNT_W = 5;
   typedef enum logic [2:0] {
      MIR_PW_IDLE = 3'b001,
      MIR_PW_RECV = 3'b010,
      MIR_PW_DROP = 3'b100
   } mir_pw_state_type;
   // One beat of an inbound port-write payload
   typedef struct packed {
      logic valid;
      logic last;
      logic [31:0] data;
   } mir_pw_beat_type;
   // Outbound maintenance transfer with raw per-window hits
   typedef struct packed {
      logic valid;
      logic write;
      logic [MIR_NWIN-1:0] hit;
   } mir_tx_req_type;
   // Inbound maintenance packet address fields
   typedef struct packed {
      logic valid;
      logic [MIR_CFG_W-1:0] cfg_offset;
      logic word_addr;
   } mir_rx_req_type;
endpackage

//--- design/mir_pw_buffer.sv
/*
 Port-write payload store, one write port and one registered read port.
 Assumes the caller keeps addresses inside DEPTH.
*/
`timescale 1ns/1ps
module mir_pw_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic hclk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data_q
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge hclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge hclk) begin
      if (rd_en) begin
         rd_data_q <= mem[rd_addr];
      end
   end
endmodule

//--- design/mir_top.sv
/*
 Maintenance event collector, port-write receiver and inbound address map,
 reached over AHB-Lite.
 Assumes hclk at 50 MHz, hresetn asynchronous active low, and that the
 translation windows report raw hits for each outbound transfer.
*/
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module mir_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire mir_pkg::mir_pw_beat_type pw_beat,
   input wire logic pw_error,
   input wire mir_pkg::mir_tx_req_type tx_req,
   input wire mir_pkg::mir_rx_req_type rx_req,
   output logic [31:0] rx_bus_addr_q,
   output logic rx_bus_addr_valid_q,
   output logic mnt_irq
);
   import mir_pkg::*;

   function automatic logic hit(input logic [MIR_AW-1:0] a,
                                input logic [MIR_AW-1:0] off);
      hit = (a[MIR_AW-1:2] == off[MIR_AW-1:2]);
   endfunction

   function automatic logic in_buf(input logic [MIR_AW-1:0] a);
      in_buf = (a[MIR_AW-1:MIR_BUF_AW+MIR_BUF_LSB]
                == MIR_OFF_PWBUF[MIR_AW-1:MIR_BUF_AW+MIR_BUF_LSB]);
   endfunction

   // Bus phase registers
   logic ap_take;
   logic dp_valid_q;
   logic dp_write_q;
   logic [MIR_AW-1:0] dp_addr_q;
   logic rd_pend_q;
   logic mem_sel_q;
   logic [31:0] rdata_q;
   logic wr_en;

   // Control and state
   logic [MIR_EV_W-1:0] enable_q;
   logic [MIR_EV_W-1:0] status;
   logic [MIR_EV_W-1:0] ev_set;
   logic [MIR_EV_W-1:0] ev_clr;
   logic [MIR_BASE_W-1:0] base_q;
   logic [MIR_NWIN-1:0] win_en_q;
   logic pw_en_q;
   logic full_q;
   logic release_pulse;
   logic [MIR_CNT_W-1:0] wptr_q;
   logic [MIR_CNT_W-1:0] pw_len_q;
   mir_pw_state_type state_q;
   logic tx_miss;
   logic pw_start_ok;
   logic pw_take;
   logic pw_done;
   logic pw_drop;
   logic mem_we;
   logic [31:0] mem_rdata;

   assign ap_take = hsel && htrans[1] && hready;
   assign wr_en = dp_valid_q && dp_write_q;
   // Reads take one wait state so a preceding write is always visible
   assign hreadyout = !rd_pend_q;
   assign hresp = 1'b0;
   assign hrdata = mem_sel_q ? mem_rdata : rdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_q <= 1'b0;
         dp_write_q <= 1'b0;
         dp_addr_q <= '0;
      end else if (hreadyout) begin
         dp_valid_q <= ap_take;
         dp_write_q <= hwrite;
         dp_addr_q <= haddr[MIR_AW-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_q <= 1'b0;
      end else begin
         rd_pend_q <= ap_take && !hwrite && hreadyout;
      end
   end

   // Register read mux, loaded in the wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
         mem_sel_q <= 1'b0;
      end else if (rd_pend_q) begin
         mem_sel_q <= in_buf(dp_addr_q);
         rdata_q <= 32'h0000_0000;
         if (hit(dp_addr_q, MIR_OFF_STATUS)) begin
            rdata_q[MIR_EV_W-1:0] <= status;
         end else if (hit(dp_addr_q, MIR_OFF_ENABLE)) begin
            rdata_q[MIR_EV_W-1:0] <= enable_q;
         end else if (hit(dp_addr_q, MIR_OFF_RXBASE)) begin
            rdata_q[MIR_BASE_LSB+:MIR_BASE_W] <= base_q;
         end else if (hit(dp_addr_q, MIR_OFF_PWSTAT)) begin
            rdata_q[MIR_PWS_FULL] <= full_q;
            rdata_q[MIR_PWS_LEN_LSB+:MIR_CNT_W] <= pw_len_q;
         end else if (hit(dp_addr_q, MIR_OFF_PWCTRL)) begin
            rdata_q[MIR_PWC_EN] <= pw_en_q;
         end else if (hit(dp_addr_q, MIR_OFF_WINEN)) begin
            rdata_q[MIR_NWIN-1:0] <= win_en_q;
         end
      end else begin
         mem_sel_q <= 1'b0;
      end
   end

   // Enables all reset to zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_q <= MIR_EV_RESET;
      end else if (wr_en && hit(dp_addr_q, MIR_OFF_ENABLE)) begin
         enable_q <= hwdata[MIR_EV_W-1:0] & MIR_EV_IMPL;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         base_q <= '0;
      end else if (wr_en && hit(dp_addr_q, MIR_OFF_RXBASE)) begin
         base_q <= hwdata[MIR_BASE_LSB+:MIR_BASE_W];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_en_q <= '0;
      end else if (wr_en && hit(dp_addr_q, MIR_OFF_WINEN)) begin
         win_en_q <= hwdata[MIR_NWIN-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pw_en_q <= 1'b0;
      end else if (wr_en && hit(dp_addr_q, MIR_OFF_PWCTRL)) begin
         pw_en_q <= hwdata[MIR_PWC_EN];
      end
   end

   assign release_pulse = wr_en && hit(dp_addr_q, MIR_OFF_PWCTRL)
                          && hwdata[MIR_PWC_REL];

   // Outbound bounds check against enabled windows only
   assign tx_miss = tx_req.valid && ((tx_req.hit & win_en_q) == '0);

   // Port-write reception
   assign pw_start_ok = pw_en_q && !full_q;
   assign pw_take = pw_beat.valid
                    && (state_q == MIR_PW_RECV
                        || (state_q == MIR_PW_IDLE && pw_start_ok));
   assign pw_done = pw_take && pw_beat.last;
   assign pw_drop = pw_beat.valid && state_q == MIR_PW_IDLE
                    && !pw_start_ok;
   // Words past the buffer end are discarded
   assign mem_we = pw_take && !wptr_q[MIR_CNT_W-1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= MIR_PW_IDLE;
      end else begin
         case (state_q)
            MIR_PW_IDLE: begin
               if (pw_beat.valid && !pw_beat.last) begin
                  state_q <= pw_start_ok ? MIR_PW_RECV : MIR_PW_DROP;
               end
            end
            MIR_PW_RECV: begin
               if (pw_done) begin
                  state_q <= MIR_PW_IDLE;
               end
            end
            MIR_PW_DROP: begin
               if (pw_beat.valid && pw_beat.last) begin
                  state_q <= MIR_PW_IDLE;
               end
            end
            default: begin
               state_q <= MIR_PW_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wptr_q <= '0;
      end else if (pw_done) begin
         wptr_q <= '0;
      end else if (mem_we) begin
         wptr_q <= wptr_q + 1'b1;
      end
   end

   // Buffer stays owned by software until released; a new store wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         full_q <= 1'b0;
         pw_len_q <= '0;
      end else if (pw_done) begin
         full_q <= 1'b1;
         pw_len_q <= mem_we ? wptr_q + 1'b1 : wptr_q;
      end else if (release_pulse) begin
         full_q <= 1'b0;
      end
   end

   mir_pw_buffer #(
      .WIDTH(32),
      .DEPTH(MIR_BUF_DEPTH),
      .AW(MIR_BUF_AW)
   ) u_buf (
      .hclk(hclk),
      .wr_en(mem_we),
      .wr_addr(wptr_q[MIR_BUF_AW-1:0]),
      .wr_data(pw_beat.data),
      .rd_en(rd_pend_q && in_buf(dp_addr_q)),
      .rd_addr(dp_addr_q[MIR_BUF_LSB+:MIR_BUF_AW]),
      .rd_data_q(mem_rdata)
   );

   // Event vector
   always_comb begin
      ev_set = '0;
      ev_set[MIR_EV_RD_MISS] = tx_miss && !tx_req.write;
      ev_set[MIR_EV_WR_MISS] = tx_miss && tx_req.write;
      ev_set[MIR_EV_STORED] = pw_done;
      ev_set[MIR_EV_DROPPED] = pw_drop;
      ev_set[MIR_EV_PW_ERR] = pw_error;
   end

   // Write-one-to-clear; zeros leave flags alone
   assign ev_clr = (wr_en && hit(dp_addr_q, MIR_OFF_STATUS))
                   ? hwdata[MIR_EV_W-1:0] & MIR_EV_IMPL : '0;

   mir_flags #(
      .W(MIR_EV_W)
   ) u_flags (
      .hclk(hclk),
      .hresetn(hresetn),
      .set(ev_set),
      .clr(ev_clr),
      .flags(status)
   );

   assign mnt_irq = |(status & enable_q);

   // Inbound local bus address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_bus_addr_q <= 32'h0000_0000;
         rx_bus_addr_valid_q <= 1'b0;
      end else begin
         rx_bus_addr_valid_q <= rx_req.valid;
         if (rx_req.valid) begin
            rx_bus_addr_q <= {base_q, rx_req.cfg_offset,
                              rx_req.word_addr, 2'b00};
         end
      end
   end

   chk_irq_rd_miss: assert property (
      @(posedge hclk) disable iff (!hresetn)
      tx_req.valid && !tx_req.write && tx_miss && enable_q[MIR_EV_RD_MISS]
      |=> mnt_irq)
      else $error("irq not raised on enabled read miss");

   chk_drop_disabled: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pw_beat.valid && state_q == MIR_PW_IDLE && !pw_en_q
      |=> status[MIR_EV_DROPPED] && !$rose(status[MIR_EV_STORED]))
      else $error("disabled port-write not dropped");

   chk_drop_full: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pw_beat.valid && state_q == MIR_PW_IDLE && full_q && !release_pulse
      |=> status[MIR_EV_DROPPED] && full_q && $stable(pw_len_q))
      else $error("port-write over unread buffer not dropped");

   chk_stored_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      state_q == MIR_PW_RECV && pw_beat.valid && pw_beat.last
      |=> status[MIR_EV_STORED] && full_q && state_q == MIR_PW_IDLE)
      else $error("accepted port-write not flagged stored");

   chk_buf_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_pend_q && in_buf(dp_addr_q)
      |=> hreadyout && mem_sel_q && hrdata == mem_rdata)
      else $error("buffer read data not presented");

   chk_wr_miss: assert property (
      @(posedge hclk) disable iff (!hresetn)
      tx_req.valid && tx_req.write && (tx_req.hit & win_en_q) == '0
      |=> status[MIR_EV_WR_MISS])
      else $error("write miss not flagged");

   chk_rd_miss: assert property (
      @(posedge hclk) disable iff (!hresetn)
      tx_req.valid && !tx_req.write && (tx_req.hit & win_en_q) == '0
      |=> status[MIR_EV_RD_MISS])
      else $error("read miss not flagged");

   chk_win_gate: assert property (
      @(posedge hclk) disable iff (!hresetn)
      tx_req.valid && (tx_req.hit & win_en_q) != '0
      |=> !$rose(status[MIR_EV_RD_MISS]) && !$rose(status[MIR_EV_WR_MISS]))
      else $error("hit in enabled window flagged as miss");

   chk_w1c_only: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ev_set == '0 ##1 ev_set == '0
      |-> status == ($past(status) & ~$past(ev_clr)))
      else $error("flag changed without write-one clear");

   chk_enable_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_en && hit(dp_addr_q, MIR_OFF_ENABLE)
      |=> enable_q == ($past(hwdata[MIR_EV_W-1:0]) & MIR_EV_IMPL))
      else $error("enable register not written");

   chk_rx_addr: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rx_req.valid |=> rx_bus_addr_valid_q
      && rx_bus_addr_q[MIR_BASE_LSB+:MIR_BASE_W] == $past(base_q)
      && rx_bus_addr_q[1:0] == 2'b00)
      else $error("inbound address malformed");

   chk_read_wait: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ap_take && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
endmodule

//--- verif/maintenance_irq_and_rx_map_tb.sv
/*
 Self-checking bench for the maintenance interrupt block.
 Assumes one AHB-Lite slave, so hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module maintenance_irq_and_rx_map_tb;
   import mir_pkg::*;
   localparam logic [31:0] A_ST = {15'h0, MIR_OFF_STATUS};
   localparam logic [31:0] A_EN = {15'h0, MIR_OFF_ENABLE};
   localparam logic [31:0] A_BASE = {15'h0, MIR_OFF_RXBASE};
   localparam logic [31:0] A_PWS = {15'h0, MIR_OFF_PWSTAT};
   localparam logic [31:0] A_CTRL = {15'h0, MIR_OFF_PWCTRL};
   localparam logic [31:0] A_WIN = {15'h0, MIR_OFF_WINEN};
   localparam logic [31:0] A_BUF = {15'h0, MIR_OFF_PWBUF};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, rx_bus_addr_valid_q, mnt_irq, pw_error;
   logic [31:0] hrdata, rx_bus_addr_q, rd, a, b;
   logic [20:0] cfg;
   logic [7:0] base;
   logic wa;
   mir_pw_beat_type pw_beat;
   mir_tx_req_type tx_req;
   mir_rx_req_type rx_req;
   int err_total = 0;
   int cmp_count = 0;
   int st = 0;
   int en = 0;
   logic [31:0] pwq[$];
   always #10 hclk = ~hclk;
   mir_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pw_beat(pw_beat), .pw_error(pw_error), .tx_req(tx_req), .rx_req(rx_req),
      .rx_bus_addr_q(rx_bus_addr_q), .rx_bus_addr_valid_q(rx_bus_addr_valid_q),
      .mnt_irq(mnt_irq));
   mir_far_model far (.hclk(hclk), .pw_beat(pw_beat), .pw_error(pw_error),
      .tx_req(tx_req), .rx_req(rx_req));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Sampled at the falling edge, which holds the value of the next rising edge
   task automatic wait_ready(output logic [31:0] d);
      logic r;
      do begin
         @(negedge hclk);
         r = hreadyout;
         d = hrdata;
         @(posedge hclk);
      end while (r !== 1'b1);
   endtask
   task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= ad;
      hwrite <= w;
      wait_ready(rd);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready(rd);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic wr(input logic [31:0] ad, input logic [31:0] wd);
      bus(1'b1, ad, wd);
   endtask
   task automatic rdchk(input logic [31:0] ad, input logic [31:0] exp);
      bus(1'b0, ad, ~exp);
      chk(rd, exp);
   endtask
   task automatic irq_chk();
      @(negedge hclk);
      chk({31'h0, mnt_irq}, {31'h0, (st & en) != 0});
      @(posedge hclk);
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      print_verdict();
   end
   initial begin
      void'($urandom(18479));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(A_ST, 32'h0);
      rdchk(A_EN, 32'h0);
      rdchk(32'h0001_0004, 32'h0);
      a = $urandom;
      wr(A_EN, a);
      en = a & 32'h73;
      rdchk(A_EN, en);
      wr(A_EN, 32'hFFFF_FFFF);
      en = 32'h73;
      far.pulse_err();
      st |= 32'h40;
      irq_chk();
      rdchk(A_ST, st);
      // Reception still disabled
      a = $urandom;
      b = $urandom;
      far.send_pw(a, b);
      st |= 32'h20;
      rdchk(A_ST, st);
      wr(A_CTRL, 32'h1);
      far.send_pw(a, b);
      pwq.push_back(a);
      pwq.push_back(b);
      st |= 32'h10;
      rdchk(A_ST, st);
      rdchk(A_PWS, 32'h201);
      rdchk(A_BUF, pwq[0]);
      rdchk(A_BUF + 32'h4, pwq[1]);
      wr(A_ST, 32'h20);
      st &= ~32'h20;
      far.send_pw(b, a);
      st |= 32'h20;
      rdchk(A_ST, st);
      rdchk(A_BUF, pwq[0]);
      wr(A_CTRL, 32'h3);
      far.send_pw(b, a);
      rdchk(A_BUF, b);
      wr(A_ST, 32'h0);
      rdchk(A_ST, st);
      wr(A_ST, 32'hFFFF_FF90);
      // Only bit 4 of the implemented field is one in this pattern
      st &= ~32'h10;
      rdchk(A_ST, st);
      wr(A_ST, 32'h7F);
      st = 0;
      irq_chk();
      far.send_tx(1'b1, 16'hFFFF);
      st |= 32'h2;
      rdchk(A_ST, st);
      wr(A_ST, 32'h2);
      st = 0;
      wr(A_WIN, 32'h0000_0008);
      rdchk(A_WIN, 32'h0000_0008);
      far.send_tx(1'b1, 16'h0008);
      // Let the release settle before the next request drives the same struct
      @(posedge hclk);
      far.send_tx(1'b0, 16'h0008);
      rdchk(A_ST, st);
      far.send_tx(1'b0, 16'h0004);
      st |= 32'h1;
      rdchk(A_ST, st);
      far.send_tx(1'b1, 16'h0004);
      st |= 32'h2;
      rdchk(A_ST, st);
      // Masking and clearing of the interrupt
      wr(A_EN, 32'h1);
      en = 32'h1;
      irq_chk();
      wr(A_EN, 32'h30);
      en = 32'h30;
      irq_chk();
      wr(A_EN, 32'h2);
      en = 32'h2;
      irq_chk();
      wr(A_ST, 32'h3);
      st = 0;
      irq_chk();
      for (int i = 0; i < 4; i++) begin
         base = 8'($urandom);
         wr(A_BASE, {base, 24'hFF_FFFF});
         rdchk(A_BASE, {base, 24'h0});
         cfg = 21'($urandom);
         wa = 1'($urandom);
         far.send_rx(cfg, wa);
         @(negedge hclk);
         chk({31'h0, rx_bus_addr_valid_q}, 32'h1);
         chk(rx_bus_addr_q, {base, cfg, wa, 2'b00});
         @(posedge hclk);
      end
      print_verdict();
   end
endmodule

//--- verif/mir_far_model.sv
/*
 Far-side source of port-writes, error pulses and maintenance traffic.
 Assumes each task is entered just after a rising hclk edge.
*/
`timescale 1ns/1ps
module mir_far_model (
   input wire logic hclk,
   output mir_pkg::mir_pw_beat_type pw_beat,
   output logic pw_error,
   output mir_pkg::mir_tx_req_type tx_req,
   output mir_pkg::mir_rx_req_type rx_req
);
   import mir_pkg::*;

   initial begin
      pw_beat = '0;
      pw_error = 1'b0;
      tx_req = '0;
      rx_req = '0;
   end
   // Released fields show inverted data so stale values never look valid
   task automatic send_pw(input logic [31:0] a, input logic [31:0] b);
      pw_beat <= '{valid: 1'b1, last: 1'b0, data: a};
      @(posedge hclk);
      pw_beat <= '{valid: 1'b1, last: 1'b1, data: b};
      @(posedge hclk);
      pw_beat <= '{valid: 1'b0, last: 1'b0, data: ~b};
   endtask
   task automatic pulse_err();
      pw_error <= 1'b1;
      @(posedge hclk);
      pw_error <= 1'b0;
   endtask
   task automatic send_tx(input logic wr, input logic [15:0] hit);
      tx_req <= '{valid: 1'b1, write: wr, hit: hit};
      @(posedge hclk);
      tx_req <= '{valid: 1'b0, write: ~wr, hit: ~hit};
   endtask
   task automatic send_rx(input logic [20:0] cfg, input logic wa);
      rx_req <= '{valid: 1'b1, cfg_offset: cfg, word_addr: wa};
      @(posedge hclk);
      rx_req <= '{valid: 1'b0, cfg_offset: ~cfg, word_addr: ~wa};
   endtask
endmodule
